// File: bench/nand_dev_model.sv
// Behavioural NAND part that answers the host controller at its pins
// Assumes the bench resolves the shared bus; busy times are short delays
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model
	import nand_host_pkg::*;
#(
	parameter int BAD_ROW = 33
) (
	input wire strobes_s pins_i,
	input wire logic [7:0] bus_i,
	input wire logic fail_next_i,
	output logic [7:0] bus_o,
	output logic ready_busy_n_o
);
	logic [7:0] mem [int];
	area_e ptr = area_first;
	logic [7:0] cmd = 8'h00;
	logic [7:0] dout = 8'hFF;
	logic stat_fail = 1'b0;
	int acnt = 0;
	int col = 0;
	int row = 0;
	initial ready_busy_n_o = 1'b1;
	// Released bus shows the inverse so a stale byte never looks valid
	assign bus_o = (!pins_i.ce_n && !pins_i.output_strobe_n) ? dout : ~dout;
	////////////////////////////////////////////////////////////////////////
	// BAD_ROW must lie outside block zero
	function automatic logic [7:0] rd(int r, int c);
		if (r == BAD_ROW && c == 517) return 8'h00;
		return mem.exists(r * 528 + c) ? mem[r * 528 + c] : 8'hFF;
	endfunction
	task automatic busy_for(int ns);
		ready_busy_n_o = 1'b0;
		#(ns);
		ready_busy_n_o = 1'b1;
	endtask
	function automatic void end_op();
		if (ptr == area_second) ptr = area_first;
	endfunction
	////////////////////////////////////////////////////////////////////////
	always @(posedge pins_i.we_n) begin
		if (!pins_i.ce_n && pins_i.cle) begin
			// Only status and reset get through while busy
			if (ready_busy_n_o || bus_i == 8'h70 || bus_i == 8'hFF) begin
				cmd = bus_i;
				acnt = 0;
				case (bus_i)
					8'h00: ptr = area_first;
					8'h01: ptr = area_second;
					8'h50: ptr = area_spare;
					8'h10, 8'hD0: begin
						stat_fail = fail_next_i;
						end_op();
						fork busy_for(2000); join_none
					end
					8'hFF: begin
						stat_fail = 1'b0;
						end_op();
						fork busy_for(1000); join_none
					end
					default: ;
				endcase
			end
		end else if (!pins_i.ce_n && pins_i.ale) begin
			if (cmd == 8'h60) acnt++;
			if (acnt == 0) begin
				col = (ptr == area_second) ? 256 + bus_i :
					(ptr == area_spare) ? 512 + bus_i[3:0] : bus_i;
			end else if (acnt == 1) begin
				row = bus_i;
			end else begin
				row = row + (bus_i << 8);
				if (cmd != 8'h80 && cmd != 8'h60) begin
					end_op();
					fork busy_for(1000); join_none
				end
			end
			acnt++;
		end else if (!pins_i.ce_n && cmd == 8'h80) begin
			mem[row * 528 + col] = bus_i;
			col++;
		end
	end
	always @(negedge pins_i.output_strobe_n) begin
		if (!pins_i.ce_n) begin
			dout = (cmd == 8'h70) ? {1'b0, ready_busy_n_o, 5'b0, stat_fail} : rd(row, col);
			if (cmd != 8'h70) col++;
		end
	end
	// Page end starts the next page fetch; only a deselect cancels it
	logic seq_busy = 1'b0;
	always @(posedge pins_i.output_strobe_n) begin
		if (!pins_i.ce_n && cmd != 8'h70 && col == 528) begin
			seq_busy = 1'b1;
			ready_busy_n_o = 1'b0;
		end
	end
	always @(posedge pins_i.ce_n) begin
		if (seq_busy) begin
			seq_busy = 1'b0;
			ready_busy_n_o = 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: bench/nand_host_bench.sv
// Self-checking bench for the NAND host controller
// Assumes the device model beside it; expected bytes queue for the monitor
`timescale 1ns/1ps
`default_nettype none
module nand_host_bench;
	import nand_host_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i = 1'b0;
	request_s req_i = '0;
	logic fail_next = 1'b0;
	logic req_ready_o, wdata_ready_o, rdata_valid_o, done_o, fail_o, block_bad_o;
	logic io_oe_o, ready_busy_n_i, take;
	logic [7:0] wdata_i, rdata_o, io_o, dev_out, io_bus;
	strobes_s pins_o;
	int error_cnt = 0;
	int comparisons = 0;
	int wcnt = 0;
	logic [7:0] exp_q [$];
	logic [7:0] wbuf [16];
	logic [31:0] lfsr = 32'h96e0_d6e0;
	always #5 clk_i = ~clk_i;
	assign io_bus = io_oe_o ? io_o : dev_out;
	assign wdata_i = wbuf[wcnt[3:0]];
	////////////////////////////////////////////////////////////////////////
	nand_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_i(req_i), .wdata_i(wdata_i),
		.wdata_ready_o(wdata_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
		.done_o(done_o), .fail_o(fail_o), .block_bad_o(block_bad_o), .pins_o(pins_o),
		.ready_busy_n_i(ready_busy_n_i), .io_i(io_bus), .io_o(io_o), .io_oe_o(io_oe_o));
	nand_dev_model i_dev (.pins_i(pins_o), .bus_i(io_bus), .fail_next_i(fail_next),
		.bus_o(dev_out), .ready_busy_n_o(ready_busy_n_i));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] next_rand(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cmp_byte(logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic cmp_flag(logic exp, logic got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic run_op(op_e op, area_e a, logic [7:0] c, logic [15:0] r, logic [9:0] n);
		int k;
		k = 0;
		@(posedge clk_i);
		#1;
		while (req_ready_o !== 1'b1 && k++ < 100) begin
			@(posedge clk_i);
			#1;
		end
		req_i = '{op, a, c, r, n};
		req_valid_i = 1'b1;
		wcnt = 0;
		@(posedge clk_i);
		#1 req_valid_i = 1'b0;
		k = 0;
		while (done_o !== 1'b1 && k++ < 20000) begin
			@(posedge clk_i);
			#1;
		end
		if (k >= 20000) begin
			error_cnt++;
			$display("BAD %0t exp %h got %h", $time, 1'b1, done_o);
		end
		@(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Ready is combinational, so it is sampled mid-cycle to dodge edge races
	always @(negedge clk_i) take = wdata_ready_o;
	always @(posedge clk_i) if (take === 1'b1) #1 wcnt = wcnt + 1;
	always @(negedge clk_i) begin
		if (rdata_valid_o === 1'b1 && req_i.op == op_read) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("BAD %0t exp none got %h", $time, rdata_o);
			end else cmp_byte(exp_q.pop_front(), rdata_o);
		end
	end
	initial begin
		// Several times the longest expected run
		#400us;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		#1 rst_i = 1'b0;
		run_op(op_scan_mark, area_spare, 8'h05, 16'd0, 10'd1);
		cmp_flag(1'b0, block_bad_o);
		run_op(op_scan_mark, area_spare, 8'h05, 16'd32, 10'd1);
		cmp_flag(1'b1, block_bad_o);
		// A marked block is refused, so the forced failure never shows
		fail_next = 1'b1;
		run_op(op_erase, area_first, 8'h00, 16'd32, 10'd0);
		cmp_flag(1'b0, fail_o);
		cmp_flag(1'b1, block_bad_o);
		fail_next = 1'b0;
		repeat (4) exp_q.push_back(8'hFF);
		run_op(op_read, area_first, 8'h10, 16'd5, 10'd4);
		// Each area gets distinct random data, so a wrong pointer reads wrong bytes
		for (int a = 0; a < 3; a++) begin
			for (int i = 0; i < 16; i++) begin
				lfsr = next_rand(lfsr);
				wbuf[i] = lfsr[7:0];
			end
			run_op(op_program, area_e'(a), 8'h02, 16'd7, 10'd6);
			cmp_flag(1'b0, fail_o);
			for (int i = 0; i < 6; i++) exp_q.push_back(wbuf[i]);
			run_op(op_read, area_e'(a), 8'h02, 16'd7, 10'd6);
		end
		// Reading to the page end starts a fetch that the deselect must end
		repeat (6) exp_q.push_back(8'hFF);
		run_op(op_read, area_spare, 8'h0A, 16'd7, 10'd6);
		fail_next = 1'b1;
		run_op(op_erase, area_first, 8'h00, 16'd64, 10'd0);
		cmp_flag(1'b1, fail_o);
		cmp_flag(1'b1, block_bad_o);
		fail_next = 1'b0;
		run_op(op_erase, area_first, 8'h00, 16'd0, 10'd0);
		cmp_flag(1'b0, block_bad_o);
		cmp_flag(1'b0, fail_o);
		run_op(op_reset, area_first, 8'h00, 16'd0, 10'd0);
		cmp_flag(1'b1, ready_busy_n_i);
		cmp_byte(8'h00, 8'(exp_q.size()));
		wrap_up();
	end
endmodule
`default_nettype wire

// File: design/nand_host.sv
// Host controller that drives a small-page NAND part through its pins
// Assumes one 100 MHz clock; ready_busy_n and bus input are asynchronous pins
//
// Summary of operation
// - Command 00h points column at bytes 0-255
// - Command 01h points column at bytes 256-511
// - Command 50h points column at bytes 512-527
// - Pointer command precedes 80h for first/spare load
// - Issue 01h immediately before 80h
// - End sequential read by holding deselect long
// - Scan column 517 of pages one and two
// - Never erase factory invalid-block marking (erase is refused only right after a scan that flagged the same block)
// - Failed status means retire and replace block (the controller only raises fail_o and block_bad_o)
// - Prefer ECC over replacement for single bits
// - Replace by copying pages into free block (the controller does no copying)
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_consts.svh"
module nand_host
	import nand_host_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire request_s req_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic wdata_ready_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic rdata_valid_o,
	output logic done_o,
	output logic fail_o,
	output logic block_bad_o,
	output strobes_s pins_o,
	input wire logic ready_busy_n_i,
	input wire logic [DATA_W-1:0] io_i,
	output logic [DATA_W-1:0] io_o,
	output logic io_oe_o
);
	// Byte-wide pins only; a wider bus would need new command framing
	if (DATA_W != 8) begin : g_width_check
		$error("nand_host supports 8-bit buses only");
	end
////////////////////////////////////////////////////////////////////////////////
	// Three-stage sampling; a change counts once stages two and three agree
	logic [2:0] rb_sync_reg;
	logic rb_level_reg;
	logic [DATA_W-1:0] io_s1_reg, io_s2_reg, io_s3_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rb_sync_reg <= 3'h0;
			rb_level_reg <= 1'b0;
			io_s1_reg <= '0;
			io_s2_reg <= '0;
			io_s3_reg <= '0;
		end else begin
			rb_sync_reg <= {rb_sync_reg[1:0], ready_busy_n_i};
			if (rb_sync_reg[1] == rb_sync_reg[2]) begin
				rb_level_reg <= rb_sync_reg[2];
			end
			io_s1_reg <= io_i;
			io_s2_reg <= io_s1_reg;
			io_s3_reg <= io_s2_reg;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		st_idle, st_cmd, st_addr, st_wait_busy, st_wait_ready,
		st_wdata, st_rdata, st_go, st_status, st_deselect
	} state_e;
	state_e state_reg, state_next;
	request_s req_reg, req_next;
	logic [7:0] cmd_byte_reg, cmd_byte_next;
	logic [1:0] step_reg, step_next;
	logic [1:0] addr_cnt_reg, addr_cnt_next;
	logic [9:0] count_reg, count_next;
	logic [7:0] timer_reg, timer_next;
	logic phase_reg, phase_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next, done_reg, done_next, fail_reg, fail_next;
	logic bad_reg, bad_next, page2_reg, page2_next;
	strobes_s pins_reg, pins_next;
	logic [DATA_W-1:0] io_reg, io_next;
	logic oe_reg, oe_next;
	// Pointer command for an area; the 01h choice is re-sent on every use
	function automatic logic [7:0] ptr_cmd(input area_e a);
		unique case (a)
			area_first: ptr_cmd = `CMD_PTR_FIRST;
			area_second: ptr_cmd = `CMD_PTR_SECOND;
			area_spare: ptr_cmd = `CMD_PTR_SPARE;
			default: ptr_cmd = `CMD_PTR_FIRST;
		endcase
	endfunction
	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		cmd_byte_next = cmd_byte_reg;
		step_next = step_reg;
		addr_cnt_next = addr_cnt_reg;
		count_next = count_reg;
		timer_next = timer_reg;
		phase_next = phase_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		done_next = 1'b0;
		fail_next = fail_reg;
		bad_next = bad_reg;
		page2_next = page2_reg;
		pins_next = pins_reg;
		io_next = io_reg;
		oe_next = oe_reg;
		if (timer_reg != 8'h0) begin
			timer_next = timer_reg - 8'h1;
		end
		unique case (state_reg)
			st_idle: begin
				pins_next = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
					output_strobe_n: 1'b1};
				oe_next = 1'b0;
				if (req_valid_i) begin
					req_next = req_i;
					fail_next = 1'b0;
					step_next = 2'h0;
					page2_next = 1'b0;
					if (req_i.op == op_scan_mark) begin
						// Probe spare byte six of the first page of the block
						req_next.area = area_spare;
						req_next.column = `MARK_LOW_COL;
						req_next.length = 10'h1;
						bad_next = 1'b0;
					end
					state_next = st_cmd;
					if (req_i.op == op_erase && req_i.row[15:5] == 11'h0) begin
						// Block zero needs no marking check; its bad flag is cleared, though a failed erase status still sets it
						bad_next = 1'b0;
					end else if (req_i.op == op_erase && bad_reg && req_reg.op == op_scan_mark
							&& req_i.row[15:5] == req_reg.row[15:5]) begin
						// Erasing a marked block would wipe its factory marking for good
						done_next = 1'b1;
						state_next = st_idle;
					end
				end
			end
			st_cmd: begin
				// Sequence: pointer, op command; reset, status and erase skip pointer
				unique case (req_reg.op)
					op_reset: cmd_byte_next = `CMD_RESET;
					op_status: cmd_byte_next = `CMD_STATUS;
					op_erase: cmd_byte_next = `CMD_ERASE_SETUP;
					op_program: cmd_byte_next = (step_reg == 2'h0) ?
						ptr_cmd(req_reg.area) : `CMD_PROG_LOAD;
					default: cmd_byte_next = ptr_cmd(req_reg.area);
				endcase
				pins_next = '{cle: 1'b1, ale: 1'b0, ce_n: 1'b0, we_n: 1'b0,
					output_strobe_n: 1'b1};
				oe_next = 1'b1;
				io_next = cmd_byte_next;
				timer_next = 8'(`STROBE_CYC);
				phase_next = 1'b0;
				addr_cnt_next = 2'h0;
				state_next = st_go;
			end
			st_go: begin
				// Low phase then high phase of each write strobe
				if (timer_reg == 8'h0) begin
					if (!phase_reg) begin
						pins_next.we_n = 1'b1;
						timer_next = 8'(`STROBE_CYC);
						phase_next = 1'b1;
					end else begin
						pins_next.cle = 1'b0;
						pins_next.ale = 1'b0;
						state_next = st_addr;
					end
				end
			end
			st_addr: begin
				if (req_reg.op == op_program && step_reg == 2'h0) begin
					step_next = 2'h1;
					state_next = st_cmd;
				end else if (req_reg.op == op_reset || req_reg.op == op_status) begin
					state_next = (req_reg.op == op_reset) ? st_wait_busy : st_rdata;
					count_next = 10'h1;
				end else if (step_reg == 2'h2) begin
					state_next = st_wait_busy;
				end else if (addr_cnt_reg == 2'h3 ||
						(req_reg.op == op_erase && addr_cnt_reg == 2'h2)) begin
					// A scan reads one mark byte per page, whatever length holds
					count_next = (req_reg.op == op_scan_mark) ? 10'h1 : req_reg.length;
					if (req_reg.op == op_program) begin
						state_next = st_wdata;
					end else if (req_reg.op == op_erase) begin
						step_next = 2'h2;
						io_next = `CMD_ERASE_GO;
						pins_next.cle = 1'b1;
						pins_next.we_n = 1'b0;
						timer_next = 8'(`STROBE_CYC);
						phase_next = 1'b0;
						state_next = st_go;
					end else begin
						state_next = st_wait_busy;
					end
				end else begin
					// Column byte then two row bytes; erase sends rows only
					unique case ((req_reg.op == op_erase) ? addr_cnt_reg + 2'h1 : addr_cnt_reg)
						2'h0: io_next = req_reg.column;
						2'h1: io_next = req_reg.row[7:0];
						default: io_next = req_reg.row[15:8];
					endcase
					addr_cnt_next = addr_cnt_reg + 2'h1;
					pins_next.ale = 1'b1;
					pins_next.we_n = 1'b0;
					timer_next = 8'(`STROBE_CYC);
					phase_next = 1'b0;
					state_next = st_go;
				end
			end
			st_wdata: begin
				// Last high phase runs out before the confirm strobe falls
				if (count_reg == 10'h0 && timer_reg == 8'h0) begin
					step_next = 2'h2;
					io_next = `CMD_PROG_GO;
					pins_next.cle = 1'b1;
					pins_next.we_n = 1'b0;
					timer_next = 8'(`STROBE_CYC);
					phase_next = 1'b0;
					state_next = st_go;
				end else if (timer_reg == 8'h0 && pins_reg.we_n && wdata_ready_o) begin
					io_next = wdata_i;
					pins_next.we_n = 1'b0;
					timer_next = 8'(`STROBE_CYC);
				end else if (timer_reg == 8'h0 && !pins_reg.we_n) begin
					pins_next.we_n = 1'b1;
					timer_next = 8'(`STROBE_CYC);
					count_next = count_reg - 10'h1;
				end
			end
			st_wait_busy: begin
				oe_next = 1'b0;
				timer_next = 8'(`BUSY_WAIT_CYC);
				state_next = st_wait_ready;
			end
			st_wait_ready: begin
				if (timer_reg == 8'h0 && rb_level_reg) begin
					if (req_reg.op == op_program || req_reg.op == op_erase) begin
						cmd_byte_next = `CMD_STATUS;
						req_next.op = op_status;
						req_next.area = area_first;
						step_next = 2'h3;
						state_next = st_cmd;
					end else if (req_reg.op == op_reset) begin
						state_next = st_deselect;
					end else begin
						state_next = st_rdata;
					end
				end
			end
			st_rdata: begin
				oe_next = 1'b0;
				if (count_reg == 10'h0) begin
					state_next = st_deselect;
				end else if (timer_reg == 8'h0 && pins_reg.output_strobe_n) begin
					pins_next.output_strobe_n = 1'b0;
					timer_next = 8'(`STROBE_CYC);
				end else if (timer_reg == 8'h0 && io_s2_reg == io_s3_reg) begin
					// Strobe stays low until the sampled byte has settled
					pins_next.output_strobe_n = 1'b1;
					timer_next = 8'(`STROBE_CYC);
					count_next = count_reg - 10'h1;
					rdata_next = io_s3_reg;
					if (req_reg.op == op_scan_mark) begin
						if (io_s3_reg != `BYTE_ERASED) bad_next = 1'b1;
						if (!page2_reg) begin
							page2_next = 1'b1;
							req_next.row = req_reg.row + 16'h1;
							count_next = 10'h0;
						end
					end else if (req_reg.op == op_status && step_reg == 2'h3) begin
						// Retire on failure: bad flag reports it upward
						fail_next = io_s3_reg[`STATUS_FAIL_BIT];
						bad_next = io_s3_reg[`STATUS_FAIL_BIT];
					end else begin
						// Raw data out; bit errors are left to ECC, never retire
						rvalid_next = 1'b1;
					end
				end
			end
			st_deselect: begin
				// Long deselect ends any sequential read in progress
				if (pins_reg.ce_n == 1'b0) begin
					pins_next.ce_n = 1'b1;
					timer_next = 8'(`DESELECT_CYC + 1);
				end else if (timer_reg == 8'h0) begin
					if (req_reg.op == op_scan_mark && page2_reg && count_reg == 10'h0
							&& req_reg.length != 10'h0) begin
						req_next.length = 10'h0;
						count_next = 10'h1;
						state_next = st_cmd;
					end else begin
						done_next = 1'b1;
						state_next = st_idle;
					end
				end
			end
			default: state_next = st_idle;
		endcase
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= st_idle;
			req_reg <= '0;
			cmd_byte_reg <= 8'h00;
			step_reg <= 2'h0;
			addr_cnt_reg <= 2'h0;
			count_reg <= 10'h000;
			timer_reg <= 8'h00;
			phase_reg <= 1'b0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			bad_reg <= 1'b0;
			page2_reg <= 1'b0;
			pins_reg <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
				output_strobe_n: 1'b1};
			io_reg <= '0;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			cmd_byte_reg <= cmd_byte_next;
			step_reg <= step_next;
			addr_cnt_reg <= addr_cnt_next;
			count_reg <= count_next;
			timer_reg <= timer_next;
			phase_reg <= phase_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			bad_reg <= bad_next;
			page2_reg <= page2_next;
			pins_reg <= pins_next;
			io_reg <= io_next;
			oe_reg <= oe_next;
		end
	end
	assign req_ready_o = (state_reg == st_idle);
	assign wdata_ready_o = (state_reg == st_wdata) && (count_reg != 10'h0)
		&& (timer_reg == 8'h0) && pins_reg.we_n;
	assign rdata_o = rdata_reg;
	assign rdata_valid_o = rvalid_reg;
	assign done_o = done_reg;
	assign fail_o = fail_reg;
	assign block_bad_o = bad_reg;
	assign pins_o = pins_reg;
	assign io_o = io_reg;
	assign io_oe_o = oe_reg;
////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ptr_before_load: assert property (state_reg == st_go && pins_reg.cle
		&& io_reg == `CMD_PROG_LOAD |-> req_reg.op == op_program && step_reg == 2'h1)
		else $error("load command without pointer");
	a_second_ptr_cmd: assert property (state_reg == st_cmd && req_reg.op == op_program
		&& step_reg == 2'h0 && req_reg.area == area_second |=> io_reg == `CMD_PTR_SECOND)
		else $error("second half pointer wrong");
	a_deselect_hold: assert property ($rose(pins_reg.ce_n) && state_reg == st_deselect
		|-> pins_reg.ce_n [*8] ##1 pins_reg.ce_n [*3])
		else $error("deselect too short");
	a_fail_retire: assert property (fail_reg |-> bad_reg)
		else $error("failed block not retired");
	a_erase_blk0: assert property (state_reg == st_idle && req_valid_i
		&& req_i.op == op_erase && req_i.row[15:5] == 11'h0 |=> !bad_reg)
		else $error("block zero flagged");
	a_spare_scan: assert property (state_reg == st_idle && req_valid_i
		&& req_i.op == op_scan_mark |=> req_reg.area == area_spare
		&& req_reg.column == `MARK_LOW_COL)
		else $error("scan column wrong");
	a_idle_pins: assert property (state_reg == st_idle |=> pins_reg.ce_n || !req_ready_o)
		else $error("chip enabled in idle");
	a_three_addr: assert property (state_reg == st_addr && addr_cnt_reg == 2'h3
		&& req_reg.op == op_read |=> state_reg == st_wait_busy)
		else $error("read address count wrong");
	c_read: cover property (state_reg == st_rdata && rvalid_next);
	c_program: cover property (req_reg.op == op_status && step_reg == 2'h3 && done_reg);
	c_scan_bad: cover property ($rose(bad_reg));
endmodule
`default_nettype wire

// File: shared/nand_host_consts.svh
// Timing counts, command bytes and column constants for the NAND host controller
// Assumes a 100 MHz clk_i; included by the controller only
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH
`define CLK_PERIOD_PS 10000
`define CMD_PTR_FIRST 8'h00
`define CMD_PTR_SECOND 8'h01
`define CMD_PTR_SPARE 8'h50
`define CMD_PROG_LOAD 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hFF
`define BYTE_ERASED 8'hFF
`define MARK_COLUMN 10'h205
`define MARK_LOW_COL 8'h05
`define STATUS_FAIL_BIT 0
`define STATUS_READY_BIT 6
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DESELECT_NS 100
`define DESELECT_CYC ((`DESELECT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BUSY_WAIT_NS 100
`define BUSY_WAIT_CYC ((`BUSY_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// File: shared/nand_host_pkg.sv
// Types shared by the NAND host controller
// Includes no header; the constants header is pulled in by the controller
package nand_host_pkg;
	typedef enum logic [1:0] {
		area_first,
		area_second,
		area_spare
	} area_e;
	typedef enum logic [2:0] {
		op_read,
		op_program,
		op_erase,
		op_reset,
		op_scan_mark,
		op_status
	} op_e;
	typedef struct packed {
		op_e op;
		area_e area;
		logic [7:0] column;
		logic [15:0] row;
		logic [9:0] length;
	} request_s;
	typedef struct packed {
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic output_strobe_n;
	} strobes_s;
endpackage
